// ===== design/cpp_pkg.sv
// constants and types shared by the channel post-processing block
package cpp_pkg;
   // register byte addresses (address = register index * 4)
   localparam logic [7:0] ADDR_CTRL = 8'h00;  // channel select, command strobes
   localparam logic [7:0] ADDR_CHCFG = 8'h04;  // per-channel config of selected channel
   localparam logic [7:0] ADDR_ASTART = 8'h08;  // analog start of selected channel
   localparam logic [7:0] ADDR_AEND = 8'h0C;  // analog end of selected channel
   localparam logic [7:0] ADDR_UMIN = 8'h10;  // minimum supply of selected channel
   localparam logic [7:0] ADDR_REF = 8'h14;  // reference channel of selected channel
   localparam logic [7:0] ADDR_HYST = 8'h18;  // global hysteresis
   localparam logic [7:0] ADDR_SUPPLY = 8'h1C;  // measured sensor supply
   localparam logic [7:0] ADDR_STATUS = 8'h20;  // relays, flags, last action
   localparam logic [7:0] ADDR_LIMMAX = 8'h24;  // max limit of selected channel
   localparam logic [7:0] ADDR_LIMMIN = 8'h28;  // min limit of selected channel
   localparam logic [7:0] ADDR_RELMODE = 8'h2C;  // relay mode and variant
   localparam logic [7:0] ADDR_CURVE = 8'h30;  // characteristic point write
   localparam logic [7:0] ADDR_OUT = 8'h34;  // last processed value of selected channel
   // chcfg field positions
   localparam int CF_DEC_LSB = 0;  // decimation factor, 7 bits, 0..99
   localparam int CF_FUNC_LSB = 8;  // output function, 3 bits
   localparam int CF_AMAX_LSB = 12;  // max action, 4 bits
   localparam int CF_AMIN_LSB = 16;  // min action, 4 bits
   localparam int CF_MA4_BIT = 20;  // 4..20 mA flag
   localparam int CF_LIN_BIT = 21;  // user characteristic active
   localparam int CF_NLIN_BIT = 22;  // sensor type is non-linear
   localparam int CF_RMAX_LSB = 24;  // relay for max, 2 bits
   localparam int CF_RMIN_LSB = 26;  // relay for min, 2 bits
   localparam int CF_RMAXEN_BIT = 28;
   localparam int CF_RMINEN_BIT = 29;
   localparam int CF_RANGE_BIT = 30;  // other range programmed
   // ctrl field positions
   localparam int CT_CLRMAX_BIT = 8;  // clear max relay assignment
   localparam int CT_CLRMIN_BIT = 9;
   localparam int CT_RELIN_BIT = 10;  // linear range reactivate command
   localparam int CT_CLRUMIN_BIT = 11;
   localparam int CT_FUNCDEF_BIT = 12;  // apply function-channel reference defaults
   localparam int CT_ADAPT_LSB = 16;  // adapter connected per relay, 4 bits
   // reset values
   localparam logic [6:0] DEC_DEFAULT = 7'h01;
   localparam logic [6:0] DEC_MAX = 7'h63;
   localparam logic [6:0] HYST_DEFAULT = 7'h0A;
   localparam logic [6:0] HYST_MAX = 7'h63;
   localparam int CURVE_POINTS = 35;
   localparam logic [1:0] VARIANT_INTERNAL = 2'h2;
   // relay modes
   typedef enum logic [1:0] {
      CPP_RM_TOTAL = 2'b00,
      CPP_RM_MAX = 2'b01,
      CPP_RM_MIN = 2'b10,
      CPP_RM_ASSIGN = 2'b11
   } cpp_relmode_t;
   // output functions
   typedef enum logic [2:0] {
      CPP_FN_MEAS = 3'b000,
      CPP_FN_DIFF = 3'b001,
      CPP_FN_MAX = 3'b010,
      CPP_FN_MIN = 3'b011,
      CPP_FN_AVG = 3'b100,
      CPP_FN_ALRM = 3'b101
   } cpp_func_t;
   // limit actions
   typedef enum logic [3:0] {
      CPP_ACT_NONE = 4'h0,
      CPP_ACT_START = 4'h1,
      CPP_ACT_STOP = 4'h2,
      CPP_ACT_INQ = 4'h3,
      CPP_ACT_TIMER_ZERO_ACTION = 4'h4,
      CPP_ACT_MACRO = 4'h8
   } cpp_act_t;
   // display markers (ascii)
   localparam logic [7:0] MARK_NONE = 8'h20;
   localparam logic [7:0] MARK_DIFF = 8'h44;
   localparam logic [7:0] MARK_MAX = 8'h48;
   localparam logic [7:0] MARK_MIN = 8'h4C;
   localparam logic [7:0] MARK_AVG = 8'h4D;
   localparam logic [7:0] MARK_ALRM = 8'h41;
   // analog full-scale codes
   localparam logic [11:0] AN_FULL = 12'hFFF;
   localparam logic [11:0] AN_4MA = 12'h333;  // 4/20 of full scale
   localparam logic [6:0] PIX_FULL = 7'h64;  // 100 pixels
   // time and timer unit
   localparam int CLK_MHZ = 200;
   localparam int TICK_US = 100000;  // 0.1 s timer unit
   localparam int TICK_CYC = CLK_MHZ * TICK_US;
endpackage

// ===== design/cpp_core.sv
// channel post-processing: linearize, decimate, monitor, alarm, scale
//
// Operation
// - up to 35-point characteristic, linear interpolation
// - non-linear sensors: base curve plus deviation
// - linear-range command re-enables stored characteristic
// - selector boards need last master-channel characteristic; channels above MASTER_LAST are passed raw
// - per-point decimation factor 00..99, default 01
// - output every Nth cycle, never if 00
// - saving uses same decimation as output
// - supply below minimum flags sensor breakage
// - cleared minimum disables supply monitoring
// - relays: total, max, min or assigned
// - adapter connected sets relay variant 2
// - max/min limits drive assigned relays, clearable
// - limit crossing triggers one optional command
// - span maps to full analog or 100 pixels
// - analog start/end stored per channel
// - 4-20 mA chosen by element flag
// - output function selects processed value
// - one-letter marker for active function
// - function channel references default first channel of its group of four (0 or 4); the difference output always uses channel 0
// - reference absolute or negative relative offset
// - common hysteresis 0..99, default 10
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module cpp_core
   import cpp_pkg::*;
#(
   parameter int NCH = 8,
   parameter int MASTER_LAST = 7  // last master-board channel
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic meas_valid,  // one-cycle: raw sample of meas_ch
   input wire logic [2:0] meas_ch,
   input wire logic signed [15:0] meas_raw,
   input wire logic [15:0] supply_mv,
   input wire logic cycle_start,  // one-cycle: new print cycle
   output logic out_valid,
   output logic save_valid,
   output logic [2:0] out_ch,
   output logic signed [15:0] out_value,
   output logic [7:0] out_marker,
   output logic [11:0] analog_code,
   output logic [6:0] pixel_code,
   output logic [3:0] relay_on,
   output logic breakage,
   output logic act_valid,
   output logic [3:0] act_code
);
   // all state of the block except curve memory and reset synchronizer
   typedef struct packed {
      logic [NCH-1:0][6:0] dec;
      logic [NCH-1:0][6:0] dcnt;
      logic [NCH-1:0][2:0] func;
      logic [NCH-1:0][3:0] amax;
      logic [NCH-1:0][3:0] amin;
      logic [NCH-1:0][1:0] rmax;
      logic [NCH-1:0][1:0] rmin;
      logic [NCH-1:0] rmaxen;
      logic [NCH-1:0] rminen;
      logic [NCH-1:0] ma4;
      logic [NCH-1:0] lin;
      logic [NCH-1:0] nlin;
      logic [NCH-1:0] oth;
      logic [NCH-1:0][15:0] ast;
      logic [NCH-1:0][15:0] aend;
      logic [NCH-1:0][15:0] umin;
      logic [NCH-1:0][7:0] ref1;
      logic [NCH-1:0][15:0] lmax;
      logic [NCH-1:0][15:0] lmin;
      logic [NCH-1:0] amx;  // max alarm active
      logic [NCH-1:0] amn;
      logic [NCH-1:0][15:0] vmax;
      logic [NCH-1:0][15:0] vmin;
      logic [NCH-1:0][15:0] vavg;
      logic [NCH-1:0][15:0] last;
      logic [NCH-1:0] brk;
      logic [NCH-1:0] tick;  // due in this print cycle
      logic [2:0] sel;
      logic [6:0] hyst;
      logic [1:0] rmode;
      logic [3:0][1:0] variant;
      logic [5:0] npts;
      logic [31:0] rdata;
      logic ov;
      logic sv;
      logic [2:0] och;
      logic [15:0] oval;
      logic [7:0] omark;
      logic [11:0] an;
      logic [6:0] pix;
      logic [3:0] rel;
      logic brkout;
      logic av;
      logic [3:0] ac;
   } cpp_state_t;

   cpp_state_t s_r, s_nxt;
   logic [1:0] rst_sync_r;
   logic rst_n;
   // characteristic memory: x breakpoints and y deviation/value
   logic signed [15:0] cx_r [CURVE_POINTS];
   logic signed [15:0] cy_r [CURVE_POINTS];
   logic signed [15:0] lin_v, proc_v, pick_v, cmp_v;
   logic [5:0] seg;
   logic signed [31:0] prod;
   logic signed [17:0] dx_span;
   logic [31:0] an_num;

   // reset release through two flops
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync_r <= 2'b00;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   // curve point writes: addr CURVE, stored at next point npts; x in [31:16], y in [15:0]
   always_ff @(posedge core_clk) begin
      if (reg_wr && reg_addr == ADDR_CURVE && s_r.npts < 6'(CURVE_POINTS)) begin
         cx_r[s_r.npts] <= reg_wdata[31:16];
         cy_r[s_r.npts] <= reg_wdata[15:0];
      end
   end

   // piecewise-linear lookup: find segment then interpolate
   always_comb begin
      seg = 6'h00;
      for (int i = 1; i < CURVE_POINTS; i++) begin
         if (6'(i) < s_r.npts && meas_raw >= cx_r[i]) begin
            seg = 6'(i);
         end
      end
      if (seg + 6'h01 < s_r.npts) begin
         dx_span = 18'(cx_r[seg + 6'h01]) - 18'(cx_r[seg]);
      end else begin
         dx_span = 18'sh0;
      end
      if (dx_span != 18'sh0) begin
         prod = 32'(32'(meas_raw - cx_r[seg]) * 32'(cy_r[seg + 6'h01] - cy_r[seg])) / 32'(dx_span);
      end else begin
         prod = 32'sh0;
      end
      lin_v = (s_r.npts == 6'h00) ? 16'sh0 : 16'(32'(cy_r[seg]) + prod);
   end

   // linearized value: user curve, or base value plus deviation, or raw
   always_comb begin
      if (!s_r.lin[meas_ch] || s_r.npts == 6'h00 || (meas_ch > 3'(MASTER_LAST))) begin
         proc_v = meas_raw;
      end else if (s_r.nlin[meas_ch]) begin
         proc_v = meas_raw + lin_v;
      end else begin
         proc_v = lin_v;
      end
   end

   // value chosen by the output function
   always_comb begin
      unique case (s_r.func[meas_ch])
         CPP_FN_DIFF: pick_v = proc_v - s_r.last[0];
         CPP_FN_MAX: pick_v = s_r.vmax[meas_ch];
         CPP_FN_MIN: pick_v = s_r.vmin[meas_ch];
         CPP_FN_AVG: pick_v = s_r.vavg[meas_ch];
         CPP_FN_ALRM: pick_v = (s_r.amx[meas_ch] || s_r.amn[meas_ch]) ? 16'sd1000 : 16'sd0;
         default: pick_v = proc_v;
      endcase
      cmp_v = proc_v;
   end

   // next-state logic
   always_comb begin
      logic [2:0] c;
      logic [15:0] span;
      logic [15:0] off;
      logic [11:0] base;
      logic due;
      c = meas_ch;
      span = 16'h0;
      off = 16'h0;
      base = 12'h0;
      due = 1'b0;
      an_num = 32'h0;
      s_nxt = s_r;
      s_nxt.ov = 1'b0;
      s_nxt.sv = 1'b0;
      s_nxt.av = 1'b0;
      // print cycle: advance per-point decimation counters
      if (cycle_start) begin
         for (int i = 0; i < NCH; i++) begin
            if (s_r.dec[i] == 7'h00) begin
               s_nxt.tick[i] = 1'b0;
            end else if (s_r.dcnt[i] + 7'h01 >= s_r.dec[i]) begin
               s_nxt.dcnt[i] = 7'h00;
               s_nxt.tick[i] = 1'b1;
            end else begin
               s_nxt.dcnt[i] = s_r.dcnt[i] + 7'h01;
               s_nxt.tick[i] = 1'b0;
            end
         end
      end
      // register writes
      if (reg_wr) begin
         unique case (reg_addr)
            ADDR_CTRL: begin
               s_nxt.sel = reg_wdata[2:0];
               if (reg_wdata[CT_CLRMAX_BIT]) s_nxt.rmaxen[reg_wdata[2:0]] = 1'b0;
               if (reg_wdata[CT_CLRMIN_BIT]) s_nxt.rminen[reg_wdata[2:0]] = 1'b0;
               if (reg_wdata[CT_RELIN_BIT]) begin
                  s_nxt.lin[reg_wdata[2:0]] = 1'b1;
                  s_nxt.oth[reg_wdata[2:0]] = 1'b0;
               end
               if (reg_wdata[CT_CLRUMIN_BIT]) s_nxt.umin[reg_wdata[2:0]] = 16'h0;
               if (reg_wdata[CT_FUNCDEF_BIT]) begin
                  s_nxt.ref1[reg_wdata[2:0]] = {6'h00, 2'b00} | 8'(reg_wdata[2:0] & 3'b100);
               end
               for (int r = 0; r < 4; r++) begin
                  if (reg_wdata[CT_ADAPT_LSB + r]) s_nxt.variant[r] = VARIANT_INTERNAL;
               end
               if (reg_wdata[31]) s_nxt.npts = 6'h00;
            end
            ADDR_CHCFG: begin
               s_nxt.dec[s_r.sel] = (reg_wdata[6:0] > DEC_MAX) ? DEC_MAX : reg_wdata[6:0];
               s_nxt.func[s_r.sel] = reg_wdata[CF_FUNC_LSB +: 3];
               s_nxt.amax[s_r.sel] = reg_wdata[CF_AMAX_LSB +: 4];
               s_nxt.amin[s_r.sel] = reg_wdata[CF_AMIN_LSB +: 4];
               s_nxt.ma4[s_r.sel] = reg_wdata[CF_MA4_BIT];
               s_nxt.lin[s_r.sel] = reg_wdata[CF_LIN_BIT] & ~reg_wdata[CF_RANGE_BIT];
               s_nxt.nlin[s_r.sel] = reg_wdata[CF_NLIN_BIT];
               s_nxt.rmax[s_r.sel] = reg_wdata[CF_RMAX_LSB +: 2];
               s_nxt.rmin[s_r.sel] = reg_wdata[CF_RMIN_LSB +: 2];
               s_nxt.rmaxen[s_r.sel] = reg_wdata[CF_RMAXEN_BIT];
               s_nxt.rminen[s_r.sel] = reg_wdata[CF_RMINEN_BIT];
               s_nxt.oth[s_r.sel] = reg_wdata[CF_RANGE_BIT];
            end
            ADDR_ASTART: s_nxt.ast[s_r.sel] = reg_wdata[15:0];
            ADDR_AEND: s_nxt.aend[s_r.sel] = reg_wdata[15:0];
            ADDR_UMIN: s_nxt.umin[s_r.sel] = reg_wdata[15:0];
            ADDR_REF: begin
               // negative value is relative to the function channel
               if (reg_wdata[7]) begin
                  s_nxt.ref1[s_r.sel] = 8'({5'h00, s_r.sel}) + reg_wdata[7:0];
               end else begin
                  s_nxt.ref1[s_r.sel] = reg_wdata[7:0];
               end
            end
            ADDR_HYST: s_nxt.hyst = (reg_wdata[6:0] > HYST_MAX) ? HYST_MAX : reg_wdata[6:0];
            ADDR_LIMMAX: s_nxt.lmax[s_r.sel] = reg_wdata[15:0];
            ADDR_LIMMIN: s_nxt.lmin[s_r.sel] = reg_wdata[15:0];
            ADDR_RELMODE: begin
               s_nxt.rmode = reg_wdata[1:0];
               for (int r = 0; r < 4; r++) s_nxt.variant[r] = reg_wdata[8 + 2 * r +: 2];
            end
            ADDR_CURVE: begin
               if (s_r.npts < 6'(CURVE_POINTS)) s_nxt.npts = s_r.npts + 6'h01;
            end
            default: ;
         endcase
      end
      // sample processing
      if (meas_valid) begin
         s_nxt.last[c] = proc_v;
         if (proc_v > $signed(s_r.vmax[c])) s_nxt.vmax[c] = proc_v;
         if (proc_v < $signed(s_r.vmin[c])) s_nxt.vmin[c] = proc_v;
         s_nxt.vavg[c] = 16'((17'($signed(s_r.vavg[c])) + 17'(proc_v)) >>> 1);  // sign kept for negative means
         s_nxt.brk[c] = (s_r.umin[c] != 16'h0) && (supply_mv < s_r.umin[c]);
         // limits with common hysteresis; events on crossing
         if (!s_r.amx[c] && cmp_v > $signed(s_r.lmax[c])) begin
            s_nxt.amx[c] = 1'b1;
            if (s_r.amax[c] != CPP_ACT_NONE) begin
               s_nxt.av = 1'b1;
               s_nxt.ac = s_r.amax[c];
            end
         end else if (s_r.amx[c] && cmp_v < $signed(s_r.lmax[c]) - $signed({9'h0, s_r.hyst})) begin
            s_nxt.amx[c] = 1'b0;
         end
         if (!s_r.amn[c] && cmp_v < $signed(s_r.lmin[c])) begin
            s_nxt.amn[c] = 1'b1;
            if (s_r.amin[c] != CPP_ACT_NONE) begin
               s_nxt.av = 1'b1;
               s_nxt.ac = s_r.amin[c];
            end
         end else if (s_r.amn[c] && cmp_v > $signed(s_r.lmin[c]) + $signed({9'h0, s_r.hyst})) begin
            s_nxt.amn[c] = 1'b0;
         end
         due = s_r.tick[c] || (cycle_start && s_r.dec[c] == 7'h01);
         s_nxt.ov = due && (s_r.dec[c] != 7'h00);
         s_nxt.sv = due && (s_r.dec[c] != 7'h00);
         if (due) s_nxt.tick[c] = 1'b0;
         s_nxt.och = c;
         s_nxt.oval = pick_v;
         unique case (s_r.func[c])
            CPP_FN_DIFF: s_nxt.omark = MARK_DIFF;
            CPP_FN_MAX: s_nxt.omark = MARK_MAX;
            CPP_FN_MIN: s_nxt.omark = MARK_MIN;
            CPP_FN_AVG: s_nxt.omark = MARK_AVG;
            CPP_FN_ALRM: s_nxt.omark = MARK_ALRM;
            default: s_nxt.omark = MARK_NONE;
         endcase
         // scaling with saturation outside the span
         span = s_r.aend[c] - s_r.ast[c];
         off = pick_v - s_r.ast[c];
         base = s_r.ma4[c] ? AN_4MA : 12'h000;
         if ($signed(pick_v) <= $signed(s_r.ast[c]) || span == 16'h0) begin
            s_nxt.an = base;
            s_nxt.pix = 7'h00;
         end else if ($signed(pick_v) >= $signed(s_r.aend[c])) begin
            s_nxt.an = AN_FULL;
            s_nxt.pix = PIX_FULL;
         end else begin
            an_num = 32'(off) * 32'(AN_FULL - base) / 32'(span);
            s_nxt.an = base + an_num[11:0];
            an_num = 32'(off) * 32'(PIX_FULL) / 32'(span);
            s_nxt.pix = an_num[6:0];
         end
      end
      // relay drive per mode
      for (int r = 0; r < 4; r++) begin
         s_nxt.rel[r] = 1'b0;
         for (int i = 0; i < NCH; i++) begin
            unique case (s_r.rmode)
               CPP_RM_TOTAL: if (s_r.amx[i] || s_r.amn[i]) s_nxt.rel[r] = 1'b1;
               CPP_RM_MAX: if (s_r.amx[i] && r == 0) s_nxt.rel[r] = 1'b1;
               CPP_RM_MIN: if (s_r.amn[i] && r == 1) s_nxt.rel[r] = 1'b1;
               default: begin
                  if (s_r.amx[i] && s_r.rmaxen[i] && s_r.rmax[i] == 2'(r)) s_nxt.rel[r] = 1'b1;
                  if (s_r.amn[i] && s_r.rminen[i] && s_r.rmin[i] == 2'(r)) s_nxt.rel[r] = 1'b1;
               end
            endcase
         end
         if (s_r.variant[r] != VARIANT_INTERNAL) s_nxt.rel[r] = 1'b0;
      end
      s_nxt.brkout = |s_r.brk;
      // read data, one cycle later
      s_nxt.rdata = 32'h0;
      if (reg_rd) begin
         unique case (reg_addr)
            ADDR_CTRL: s_nxt.rdata = {26'h0, s_r.npts};
            ADDR_CHCFG: s_nxt.rdata = {1'b0, s_r.oth[s_r.sel], s_r.rminen[s_r.sel], s_r.rmaxen[s_r.sel],
               s_r.rmin[s_r.sel], s_r.rmax[s_r.sel], 1'b0, s_r.nlin[s_r.sel], s_r.lin[s_r.sel],
               s_r.ma4[s_r.sel], s_r.amin[s_r.sel], s_r.amax[s_r.sel], 1'b0, s_r.func[s_r.sel],
               1'b0, s_r.dec[s_r.sel]};
            ADDR_ASTART: s_nxt.rdata = {16'h0, s_r.ast[s_r.sel]};
            ADDR_AEND: s_nxt.rdata = {16'h0, s_r.aend[s_r.sel]};
            ADDR_UMIN: s_nxt.rdata = {16'h0, s_r.umin[s_r.sel]};
            ADDR_REF: s_nxt.rdata = {24'h0, s_r.ref1[s_r.sel]};
            ADDR_HYST: s_nxt.rdata = {25'h0, s_r.hyst};
            ADDR_SUPPLY: s_nxt.rdata = {16'h0, supply_mv};
            ADDR_STATUS: s_nxt.rdata = {20'h0, s_r.ac, 3'h0, s_r.brkout, s_r.rel};
            ADDR_LIMMAX: s_nxt.rdata = {16'h0, s_r.lmax[s_r.sel]};
            ADDR_LIMMIN: s_nxt.rdata = {16'h0, s_r.lmin[s_r.sel]};
            ADDR_RELMODE: s_nxt.rdata = {16'h0, s_r.variant, 6'h0, s_r.rmode};
            ADDR_OUT: s_nxt.rdata = {16'h0, s_r.last[s_r.sel]};
            default: s_nxt.rdata = 32'h0;
         endcase
      end
   end

   // state register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
         for (int i = 0; i < NCH; i++) begin
            s_r.dec[i] <= DEC_DEFAULT;
            s_r.vmax[i] <= 16'h8000;
            s_r.vmin[i] <= 16'h7FFF;
            s_r.lmax[i] <= 16'h7FFF;
            s_r.lmin[i] <= 16'h8000;
         end
         s_r.hyst <= HYST_DEFAULT;
         s_r.omark <= MARK_NONE;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign reg_rdata = s_r.rdata;
   assign out_valid = s_r.ov;
   assign save_valid = s_r.sv;
   assign out_ch = s_r.och;
   assign out_value = s_r.oval;
   assign out_marker = s_r.omark;
   assign analog_code = s_r.an;
   assign pixel_code = s_r.pix;
   assign relay_on = s_r.rel;
   assign breakage = s_r.brkout;
   assign act_valid = s_r.av;
   assign act_code = s_r.ac;

   // saving follows output exactly
   chk_save_follows_out: assert property (@(posedge core_clk) disable iff (!rst_n)
      save_valid == out_valid) else $error("save and output decimation differ");
   // factor zero never outputs
   chk_dec_zero_mute: assert property (@(posedge core_clk) disable iff (!rst_n)
      meas_valid && s_r.dec[meas_ch] == 7'h00 |=> !out_valid) else $error("factor 00 produced output");
   // hysteresis stays within range
   chk_hyst_range: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_r.hyst <= HYST_MAX) else $error("hysteresis above 99");
   // breakage flag follows supply check
   chk_break_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
      meas_valid && s_r.umin[meas_ch] == 16'h0 |=> !s_r.brk[$past(meas_ch)]) else $error("monitor not disabled");
   // analog never below the 4 mA floor
   chk_ma4_floor: assert property (@(posedge core_clk) disable iff (!rst_n)
      meas_valid && s_r.ma4[meas_ch] |=> analog_code >= AN_4MA) else $error("analog below 4 mA");
   // pixel output saturates at 100
   chk_pix_sat: assert property (@(posedge core_clk) disable iff (!rst_n)
      pixel_code <= PIX_FULL) else $error("pixel above 100");
   // action pulse carries a command
   chk_act_code: assert property (@(posedge core_clk) disable iff (!rst_n)
      act_valid |-> act_code != CPP_ACT_NONE) else $error("empty action");
   // relay 0 only drives with internal variant
   chk_relay_var: assert property (@(posedge core_clk) disable iff (!rst_n)
      relay_on[0] |-> $past(s_r.variant[0]) == VARIANT_INTERNAL) else $error("relay without variant 2");
endmodule
`default_nettype wire

// ===== bench/cpp_sensor_model.sv
// sensor connector model: turns bench requests into one-cycle samples
`timescale 1ns/100ps
`default_nettype none
module cpp_sensor_model (
   input wire logic core_clk,
   input wire logic smp_req,
   input wire logic signed [15:0] smp_raw,
   input wire logic [15:0] smp_supply,
   output logic meas_valid = 1'b0,
   output logic [2:0] meas_ch = 3'h0,
   output logic signed [15:0] meas_raw = 16'h0,
   output logic [15:0] supply_mv = 16'h3000
);
   // sample lines carry junk outside the strobe, inverted every cycle
   always @(posedge core_clk) begin
      meas_valid <= smp_req;
      meas_ch <= smp_req ? 3'h0 : ~meas_ch;
      meas_raw <= smp_req ? smp_raw : ~meas_raw;
      supply_mv <= smp_supply;
   end
endmodule
`default_nettype wire

// ===== bench/channel_postprocessing_tb_top.sv
// self-checking bench for the channel post-processing block
`timescale 1ns/100ps
`default_nettype none
module channel_postprocessing_tb_top;
   import cpp_pkg::*;
   logic core_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, cycle_start = 1'b0, smp_req = 1'b0;
   logic [7:0] reg_addr = 8'h00, out_marker;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, rdv;
   logic signed [15:0] smp_raw = 16'h0, meas_raw, out_value;
   logic [15:0] smp_supply = 16'h3000, supply_mv;
   logic meas_valid, out_valid, save_valid, breakage, act_valid;
   logic [2:0] meas_ch, out_ch;
   logic [11:0] analog_code;
   logic [6:0] pixel_code;
   logic [3:0] relay_on, act_code;
   int miscompares = 0, check_count = 0, n_out, n_sv;
   logic [7:0] marks [6] = '{MARK_NONE, MARK_DIFF, MARK_MAX, MARK_MIN, MARK_AVG, MARK_ALRM};
   always #2.5 core_clk = ~core_clk;
   cpp_sensor_model u_model (.core_clk, .smp_req, .smp_raw, .smp_supply, .meas_valid, .meas_ch, .meas_raw,
      .supply_mv);
   cpp_core u_dut (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .meas_valid,
      .meas_ch, .meas_raw, .supply_mv, .cycle_start, .out_valid, .save_valid, .out_ch, .out_value, .out_marker,
      .analog_code, .pixel_code, .relay_on, .breakage, .act_valid, .act_code);
   // compares and counts
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one-cycle register write and read
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      rdv = reg_rdata;
   endtask
   // one sample through the model, output strobes looked at in their cycle
   task automatic send(input logic signed [15:0] raw);
      @(posedge core_clk);
      smp_req <= 1'b1;
      smp_raw <= raw;
      @(posedge core_clk);
      smp_req <= 1'b0;
      @(posedge core_clk);
      @(negedge core_clk);
      n_out += out_valid;
      n_sv += save_valid;
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // watchdog against a hang
   initial begin
      #100000;
      miscompares++;
      print_verdict;
   end
   // main sequence
   initial begin
      repeat (5) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (5) @(posedge core_clk);
      check(out_marker, MARK_NONE);
      rd(ADDR_HYST);
      check(rdv[6:0], HYST_DEFAULT);
      rd(ADDR_CHCFG);
      check(rdv[6:0], DEC_DEFAULT);
      wr(ADDR_CHCFG, 32'h63);
      wr(8'hFC, 32'h0);
      rd(ADDR_CHCFG);
      check(rdv[6:0], DEC_MAX);
      // factor 0 never outputs, factor 3 every third cycle
      for (int f = 0; f <= 3; f += 3) begin
         wr(ADDR_CHCFG, f);
         n_out = 0;
         n_sv = 0;
         repeat (6) begin
            @(posedge core_clk);
            cycle_start <= 1'b1;
            @(posedge core_clk);
            cycle_start <= 1'b0;
            send(16'h10);
         end
         check(n_out, f / 3 * 2);
         check(n_sv, n_out);
      end
      // every output function with its marker
      for (int i = 0; i < 6; i++) begin
         wr(ADDR_CHCFG, 32'h1 | (i << CF_FUNC_LSB));
         send(16'h10);
         check(out_marker, marks[i]);
      end
      check(out_value, 16'h0);
      wr(ADDR_CHCFG, 32'h1);
      wr(ADDR_ASTART, 32'h0);
      wr(ADDR_AEND, 32'h3E8);
      send(16'sd2000);
      check(out_value, 16'h07D0);
      check(analog_code, AN_FULL);
      check(pixel_code, PIX_FULL);
      send(-16'sd100);
      check(analog_code, 12'h000);
      check(pixel_code, 7'h00);
      wr(ADDR_CHCFG, 32'h0010_0001);
      send(-16'sd100);
      check(analog_code, AN_4MA);
      // supply below the minimum, then monitoring switched off
      wr(ADDR_UMIN, 32'h1388);
      smp_supply <= 16'h0FA0;
      send(16'h10);
      @(negedge core_clk);
      check(breakage, 1'b1);
      wr(ADDR_CTRL, 32'h1 << CT_CLRUMIN_BIT);
      send(16'h10);
      @(negedge core_clk);
      check(breakage, 1'b0);
      // user curve, range override and reactivation, then deviation mode
      wr(ADDR_CURVE, 32'h0);
      wr(ADDR_CURVE, 32'h0100_0200);
      wr(ADDR_CHCFG, 32'h0020_0001);
      send(16'h80);
      check(out_value, 16'h0100);
      wr(ADDR_CHCFG, 32'h4020_0001);
      send(16'h80);
      check(out_value, 16'h0080);
      wr(ADDR_CTRL, 32'h1 << CT_RELIN_BIT);
      send(16'h80);
      check(out_value, 16'h0100);
      wr(ADDR_CHCFG, 32'h0060_0001);
      send(16'h80);
      check(out_value, 16'h0180);
      // max limit with start action on relay 2, then cleared, then total alarm
      wr(ADDR_RELMODE, 32'h3);
      wr(ADDR_CTRL, 32'h1 << (CT_ADAPT_LSB + 2));
      wr(ADDR_LIMMAX, 32'h100);
      wr(ADDR_CHCFG, 32'h1200_1001);
      send(16'h200);
      check(act_valid, 1'b1);
      check(act_code, CPP_ACT_START);
      check(out_ch, 3'h0);
      @(negedge core_clk);
      check(relay_on, 4'h4);
      rd(ADDR_RELMODE);
      check(rdv[15:0], 16'h2003);
      wr(ADDR_CTRL, 32'h1 << CT_CLRMAX_BIT);
      repeat (2) @(negedge core_clk);
      check(relay_on, 4'h0);
      wr(ADDR_RELMODE, 32'hAA00);
      repeat (2) @(negedge core_clk);
      check(relay_on, 4'hF);
      // relative and default first reference of channel 5
      wr(ADDR_CTRL, 32'h5);
      wr(ADDR_REF, 32'hFE);
      rd(ADDR_REF);
      check(rdv[7:0], 8'h03);
      wr(ADDR_CTRL, 32'h5 | (1 << CT_FUNCDEF_BIT));
      rd(ADDR_REF);
      check(rdv[7:0], 8'h04);
      print_verdict;
   end
endmodule
`default_nettype wire
